/* File: verilog/sbw_pkg.sv */
// shared constants and state encodings for the burst sram bus-cycle pair
// assumes both ends import this package and the link interface uses it by scope
package sbw_pkg;

  // one byte lane carries eight data bits plus parity
  localparam int LANE_W = 9;
  // the two documented organisations
  localparam int DATA_W_X36 = 36;
  localparam int DATA_W_X18 = 18;
  // default supplied address width (word pairs)
  localparam int ADDR_W_DEF = 10;
  // every bus cycle is exactly this many beats
  localparam int BURST_LEN = 2;
  // internal address bit of the first and the second beat
  localparam logic BEAT_FIRST = 1'b0;
  localparam logic BEAT_SECOND = 1'b1;
  // write staging fifo depth and room kept for beats already on the way
  localparam int FIFO_DEPTH = 8;
  localparam int WR_HEADROOM = 4;

  // read bus-cycle machine
  typedef enum logic [2:0] {
    SBW_RD_IDLE  = 3'b001,
    SBW_RD_BEAT0 = 3'b010,
    SBW_RD_BEAT1 = 3'b100
  } sbw_rd_state_t;

  // write bus-cycle machine
  typedef enum logic [1:0] {
    SBW_WR_IDLE  = 2'b01,
    SBW_WR_BEAT1 = 2'b10
  } sbw_wr_state_t;

  // controller command issue machine
  typedef enum logic [1:0] {
    SBW_C_IDLE   = 2'b01,
    SBW_C_SECOND = 2'b10
  } sbw_ctl_state_t;

endpackage

/* File: verilog/sbw_if.sv */
// link between the external memory controller and the burst sram
// assumes one system clock; the controller drives the k phase on it
`timescale 1ns/100ps
interface sbw_if #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 10
) ();
  localparam int LANES = DATA_W / sbw_pkg::LANE_W;

  logic k; // true clock phase, high on the k edge cycle
  logic rd_sel_n;
  logic wr_sel_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] d;
  logic [LANES-1:0] byte_lane_write_mask_n;
  logic [DATA_W-1:0] q;
  logic q_oe_n; // low while the sram drives q
  logic wr_ready; // staging room for one more write burst

  modport dev (
    input k, rd_sel_n, wr_sel_n, addr, d, byte_lane_write_mask_n,
    output q, q_oe_n, wr_ready
  );
  modport ctl (
    output k, rd_sel_n, wr_sel_n, addr, d, byte_lane_write_mask_n,
    input q, q_oe_n, wr_ready
  );
endinterface

/* File: verilog/sbw_device.sv */
// burst sram end: bus-cycle control, byte-masked writes, staging fifo
// assumes link inputs synchronous to clk_i and k toggling every cycle
`timescale 1ns/100ps

// write staging fifo, width and depth shape the storage
module sbw_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  // honest flags straight from the occupancy count
  assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rp_q];
  assign level_o = cnt_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  // pointers wrap only for power-of-two depths
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// Summary of operation
// - x36: four low masks gate four lanes
// - x18: two low masks gate two lanes
// - masks matter only inside started write bursts
// - each beat uses its own sampled mask
// - internal address bit: word +0 then +1
// - every bus cycle is exactly two beats
// - read and write machines run concurrently
// - both selects together: read starts, write dropped
// - machines start only on true k phase, then step every cycle
// - low selects sampled on k; idle q floats
// - write beats on k then complementary phase
module sbw_device
  import sbw_pkg::*;
#(
  parameter int DATA_W = DATA_W_X36,
  parameter int ADDR_W = ADDR_W_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  sbw_if.dev link
);
  localparam int LANES = DATA_W / LANE_W;
  localparam int IDX_W = ADDR_W + 1;
  localparam int MEM_DEPTH = 1 << IDX_W;
  localparam int FW = IDX_W + DATA_W + LANES;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  sbw_rd_state_t rd_state_q;
  sbw_wr_state_t wr_state_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [DATA_W-1:0] q_q;
  logic q_oe_n_q;
  logic wr_ready_q;
  logic rd_start;
  logic wr_start;
  logic push;
  logic push_ready;
  logic [FW-1:0] push_word;
  logic drain_valid;
  logic drain_ready;
  logic [FW-1:0] drain_word;
  logic [LW-1:0] level;
  logic [IDX_W-1:0] wr_idx;
  logic [DATA_W-1:0] wr_data;
  logic [LANES-1:0] wr_mask_n;
  logic [IDX_W-1:0] rd_idx;
  logic [DATA_W-1:0] rd_word;

  // selects count only on the true k phase; read wins a tie
  assign rd_start = link.k && !link.rd_sel_n;
  assign wr_start = link.k && !link.wr_sel_n && link.rd_sel_n;

  // read machine: two beats, +0 then +1, may start again on beat 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_state_q <= SBW_RD_IDLE;
    end else begin
      case (rd_state_q)
        SBW_RD_IDLE: begin
          if (rd_start) begin
            rd_state_q <= SBW_RD_BEAT0;
          end
        end
        SBW_RD_BEAT0: begin
          rd_state_q <= SBW_RD_BEAT1;
        end
        SBW_RD_BEAT1: begin
          rd_state_q <= rd_start ? SBW_RD_BEAT0 : SBW_RD_IDLE;
        end
        default: begin
          rd_state_q <= SBW_RD_IDLE;
        end
      endcase
    end
  end

  // read address latched with the command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_addr_q <= '0;
    end else if (rd_start) begin
      rd_addr_q <= link.addr;
    end
  end

  // write machine runs beside the read one, never waits for it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_state_q <= SBW_WR_IDLE;
      wr_addr_q <= '0;
    end else begin
      case (wr_state_q)
        SBW_WR_IDLE: begin
          if (wr_start) begin
            wr_state_q <= SBW_WR_BEAT1;
            wr_addr_q <= link.addr;
          end
        end
        SBW_WR_BEAT1: begin
          // second beat taken on the complementary phase, burst ends
          wr_state_q <= SBW_WR_IDLE;
        end
        default: begin
          wr_state_q <= SBW_WR_IDLE;
        end
      endcase
    end
  end

  // only beats of a started write enter the fifo, each with its mask
  assign push = wr_start || (wr_state_q == SBW_WR_BEAT1);
  always_comb begin
    if (wr_state_q == SBW_WR_BEAT1) begin
      push_word = {wr_addr_q, BEAT_SECOND, link.d,
                   link.byte_lane_write_mask_n};
    end else begin
      push_word = {link.addr, BEAT_FIRST, link.d,
                   link.byte_lane_write_mask_n};
    end
  end

  // array is shared with reads, so the drain yields to any read burst;
  // a stream of back-to-back reads therefore holds writes in the fifo
  assign drain_ready = (rd_state_q == SBW_RD_IDLE);

  sbw_fifo #(
    .W(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_stage (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(push_ready),
    .in_data_i(push_word),
    .out_valid_o(drain_valid),
    .out_ready_i(drain_ready),
    .out_data_o(drain_word),
    .level_o(level)
  );

  // headroom covers a burst already issued before ready fell
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ready_q <= 1'b0;
    end else begin
      wr_ready_q <= push_ready &&
        (level <= LW'(FIFO_DEPTH - WR_HEADROOM));
    end
  end

  assign wr_idx = drain_word[FW-1 -: IDX_W];
  assign wr_data = drain_word[LANES +: DATA_W];
  assign wr_mask_n = drain_word[LANES-1:0];
  assign rd_idx = {rd_addr_q,
                   (rd_state_q == SBW_RD_BEAT1) ? BEAT_SECOND : BEAT_FIRST};

  // one array per lane; a high mask leaves that lane untouched
  for (genvar ln = 0; ln < LANES; ln++) begin : g_lane
    logic [LANE_W-1:0] lane_mem_q [MEM_DEPTH];

    always_ff @(posedge clk_i) begin
      if (drain_valid && drain_ready && !wr_mask_n[ln]) begin
        lane_mem_q[wr_idx] <= wr_data[ln*LANE_W +: LANE_W];
      end
    end

    assign rd_word[ln*LANE_W +: LANE_W] = lane_mem_q[rd_idx];
  end

  // q driven only during the two read beats, floated otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_q <= '0;
      q_oe_n_q <= 1'b1;
    end else if (rd_state_q != SBW_RD_IDLE) begin
      q_q <= rd_word;
      q_oe_n_q <= 1'b0;
    end else begin
      q_oe_n_q <= 1'b1;
    end
  end

  assign link.q = q_q;
  assign link.q_oe_n = q_oe_n_q;
  assign link.wr_ready = wr_ready_q;
endmodule

/* File: verilog/sbw_ctrl.sv */
// external memory controller end: issues read and write bursts
// assumes one request at a time from user logic, same clock as the sram
`timescale 1ns/100ps
module sbw_ctrl
  import sbw_pkg::*;
#(
  parameter int DATA_W = DATA_W_X36,
  parameter int ADDR_W = ADDR_W_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata0_i,
  input wire logic [DATA_W-1:0] req_wdata1_i,
  input wire logic [DATA_W/LANE_W-1:0] req_mask0_n_i,
  input wire logic [DATA_W/LANE_W-1:0] req_mask1_n_i,
  output logic req_ready_o,
  output logic [DATA_W-1:0] rsp_data_o,
  output logic rsp_valid_o,
  output logic rsp_second_o,
  sbw_if.ctl link
);
  localparam int LANES = DATA_W / LANE_W;

  sbw_ctl_state_t state_q;
  logic k_q;
  logic ready_q;
  logic rd_sel_n_q;
  logic wr_sel_n_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] d_q;
  logic [LANES-1:0] mask_n_q;
  logic [DATA_W-1:0] d1_q;
  logic [LANES-1:0] mask1_n_q;
  logic [DATA_W-1:0] rsp_data_q;
  logic rsp_valid_q;
  logic rsp_second_q;
  logic accept;

  // requests are taken only in the cycle before a true k phase
  assign accept = req_valid_i && ready_q;

  // k divider and ready window; ready waits for sram staging room
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      k_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      k_q <= !k_q;
      ready_q <= k_q && link.wr_ready;
    end
  end

  // issue: selects with beat 0, then beat 1 with selects released
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SBW_C_IDLE;
      rd_sel_n_q <= 1'b1;
      wr_sel_n_q <= 1'b1;
      addr_q <= '0;
      d_q <= '0;
      mask_n_q <= '1;
      d1_q <= '0;
      mask1_n_q <= '1;
    end else begin
      case (state_q)
        SBW_C_IDLE: begin
          if (accept) begin
            // never both selects, so no request is lost to precedence
            rd_sel_n_q <= req_write_i;
            wr_sel_n_q <= !req_write_i;
            addr_q <= req_addr_i;
            d_q <= req_wdata0_i;
            mask_n_q <= req_write_i ? req_mask0_n_i : '1;
            d1_q <= req_wdata1_i;
            mask1_n_q <= req_mask1_n_i;
            state_q <= SBW_C_SECOND;
          end
        end
        SBW_C_SECOND: begin
          rd_sel_n_q <= 1'b1;
          wr_sel_n_q <= 1'b1;
          d_q <= d1_q;
          mask_n_q <= wr_sel_n_q ? '1 : mask1_n_q;
          state_q <= SBW_C_IDLE;
        end
        default: begin
          state_q <= SBW_C_IDLE;
        end
      endcase
    end
  end

  // capture each read beat as the sram drives it, +0 first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_data_q <= '0;
      rsp_valid_q <= 1'b0;
      rsp_second_q <= 1'b0;
    end else begin
      rsp_valid_q <= !link.q_oe_n;
      if (!link.q_oe_n) begin
        rsp_data_q <= link.q;
        rsp_second_q <= rsp_valid_q && !rsp_second_q;
      end else begin
        rsp_second_q <= 1'b0;
      end
    end
  end

  assign req_ready_o = ready_q;
  assign rsp_data_o = rsp_data_q;
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_second_o = rsp_second_q;
  assign link.k = k_q;
  assign link.rd_sel_n = rd_sel_n_q;
  assign link.wr_sel_n = wr_sel_n_q;
  assign link.addr = addr_q;
  assign link.d = d_q;
  assign link.byte_lane_write_mask_n = mask_n_q;
endmodule

/* File: tb/sbw_link_checker.sv */
// concurrent checks on the link between controller and sram end
// assumes instantiation beside the link interface, one clock domain
`timescale 1ns/100ps
module sbw_link_checker #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic k,
  input wire logic rd_sel_n,
  input wire logic wr_sel_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] d,
  input wire logic [DATA_W/sbw_pkg::LANE_W-1:0] byte_lane_write_mask_n,
  input wire logic [DATA_W-1:0] q,
  input wire logic q_oe_n,
  input wire logic wr_ready
);
  logic rd_cmd;
  logic wr_cmd;
  // selects only count on the true phase
  assign rd_cmd = k && !rd_sel_n;
  assign wr_cmd = k && !wr_sel_n;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_read_beats: assert property (rd_cmd |=> ##1 !q_oe_n [*2])
    else $error("read burst not driven for two beats");
  a_read_end: assert property (rd_cmd ##2 !rd_cmd |-> ##2 q_oe_n)
    else $error("read data driven past two beats");
  a_q_float: assert property
    (!q_oe_n |-> $past(rd_cmd, 2) || $past(rd_cmd, 3))
    else $error("read data driven without a read");
  // the edge that drops reset still sees k parked low, so skip it
  a_k_phase: assert property (!$past(rst_i) |-> k != $past(k))
    else $error("true phase stopped toggling");
  a_one_select: assert property (!(!rd_sel_n && !wr_sel_n))
    else $error("both selects low together");
  a_select_k: assert property ((!rd_sel_n || !wr_sel_n) |-> k)
    else $error("select outside the true phase");
  a_beat_two: assert property
    ((rd_cmd || wr_cmd) |=> !k && rd_sel_n && wr_sel_n)
    else $error("second beat not on the complementary phase");
  a_write_room: assert property (wr_cmd |-> $past(wr_ready, 2))
    else $error("write started without staging room");

  c_read: cover property (rd_cmd);
  c_write: cover property (wr_cmd);
  c_overlap: cover property (rd_cmd ##2 wr_cmd);
  c_full: cover property (!wr_ready);
endmodule

/* File: tb/sbw_bench.sv */
// bench: controller and x36 sram end face to face; an x18 sram end
// is driven straight from here for masks and select clashes
// assumes the design ports and package constants as declared
`timescale 1ns/100ps
module sram_burst_byte_write_control_bench;
  import sbw_pkg::*;
  logic clk_i;
  logic rst_i;
  logic rv;
  logic rw;
  logic [9:0] ra;
  logic [35:0] w0;
  logic [35:0] w1;
  logic [3:0] m0;
  logic [3:0] m1;
  logic rdy;
  logic [35:0] rsp;
  logic rsp_v;
  logic rsp_2;
  int num_errors;
  int checks_done;
  int cyc;
  logic [35:0] mem1 [2048];
  logic [35:0] mem2 [2048];
  logic [36:0] expq [$];

  sbw_if #(.DATA_W(36)) l1 ();
  sbw_if #(.DATA_W(18)) l2 ();
  sbw_ctrl sbw_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(rv),
    .req_write_i(rw), .req_addr_i(ra), .req_wdata0_i(w0), .req_wdata1_i(w1),
    .req_mask0_n_i(m0), .req_mask1_n_i(m1), .req_ready_o(rdy),
    .rsp_data_o(rsp), .rsp_valid_o(rsp_v), .rsp_second_o(rsp_2),
    .link(l1.ctl));
  sbw_device sbw_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(l1.dev));
  sbw_device #(.DATA_W(18)) sbw_device_x18_inst (.clk_i(clk_i),
    .rst_i(rst_i), .link(l2.dev));
  sbw_link_checker #(.DATA_W(36), .ADDR_W(10)) sbw_link_checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .k(l1.k), .rd_sel_n(l1.rd_sel_n),
    .wr_sel_n(l1.wr_sel_n), .addr(l1.addr), .d(l1.d),
    .byte_lane_write_mask_n(l1.byte_lane_write_mask_n), .q(l1.q),
    .q_oe_n(l1.q_oe_n), .wr_ready(l1.wr_ready));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [36:0] got, input logic [36:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // model of a byte-masked word update, low mask bit writes the lane
  function automatic logic [35:0] mrg(input logic [35:0] o,
      input logic [35:0] n, input logic [3:0] mn);
    mrg = o;
    for (int i = 0; i < 4; i++)
      if (!mn[i]) mrg[i*9 +: 9] = n[i*9 +: 9];
  endfunction

  // watchdog; also the true phase of the directly driven end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    l2.k <= rst_i ? 1'b0 : ~l2.k;
    if (cyc == 3000) begin
      num_errors++;
      test_done();
    end
  end

  // returned beats compared in order, order bit included
  always @(posedge clk_i)
    if (rsp_v === 1'b1)
      chk({rsp_2, rsp}, expq.pop_front());

  // valid is left high; the caller lowers it through idle
  task automatic req(input logic wr, input logic [9:0] a,
      input logic [35:0] d0, input logic [35:0] d1,
      input logic [3:0] n0, input logic [3:0] n1);
    if (wr) begin
      mem1[{a, 1'b0}] = mrg(mem1[{a, 1'b0}], d0, n0);
      mem1[{a, 1'b1}] = mrg(mem1[{a, 1'b1}], d1, n1);
    end else begin
      expq.push_back({1'b0, mem1[{a, 1'b0}]});
      expq.push_back({1'b1, mem1[{a, 1'b1}]});
    end
    rv <= 1'b1;
    rw <= wr;
    ra <= a;
    w0 <= d0;
    w1 <= d1;
    m0 <= n0;
    m1 <= n1;
    do @(posedge clk_i); while (rdy !== 1'b1);
  endtask

  task automatic idle(input int n);
    rv <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask

  // one command on the direct link, beats on k then complementary phase
  task automatic cmd2(input logic rn, input logic wn, input logic [9:0] a,
      input logic [17:0] d0, input logic [17:0] d1,
      input logic [1:0] n0, input logic [1:0] n1);
    do @(posedge clk_i); while (l2.k !== 1'b0);
    l2.rd_sel_n <= rn;
    l2.wr_sel_n <= wn;
    l2.addr <= a;
    l2.d <= d0;
    l2.byte_lane_write_mask_n <= n0;
    @(posedge clk_i);
    l2.rd_sel_n <= 1'b1;
    l2.wr_sel_n <= 1'b1;
    l2.d <= d1;
    l2.byte_lane_write_mask_n <= n1;
    @(posedge clk_i);
    // idle lanes flip and masks go low, so stray writes would show
    l2.d <= ~d1;
    l2.byte_lane_write_mask_n <= 2'b00;
  endtask

  task automatic wr2(input logic [9:0] a, input logic [17:0] d0,
      input logic [17:0] d1, input logic [1:0] n0, input logic [1:0] n1);
    mem2[{a, 1'b0}] = mrg(mem2[{a, 1'b0}], {18'h0, d0}, {2'b11, n0});
    mem2[{a, 1'b1}] = mrg(mem2[{a, 1'b1}], {18'h0, d1}, {2'b11, n1});
    cmd2(1'b1, 1'b0, a, d0, d1, n0, n1);
  endtask

  // read, optionally with the write select low as well
  task automatic rd2(input logic [9:0] a, input logic wn);
    cmd2(1'b0, wn, a, 18'h3FFFF, 18'h3FFFF, 2'b00, 2'b00);
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_i);
      chk({1'b0, l2.q_oe_n, 17'h0, l2.q}, {19'h0, mem2[{a, b[0]}][17:0]});
    end
    @(posedge clk_i);
    chk({36'h0, l2.q_oe_n}, 37'h1);
  endtask

  initial begin
    rst_i = 1'b1;
    rv = 1'b0;
    rw = 1'b0;
    ra = 10'h000;
    w0 = 36'h0;
    w1 = 36'h0;
    m0 = 4'hF;
    m1 = 4'hF;
    l2.rd_sel_n = 1'b1;
    l2.wr_sel_n = 1'b1;
    l2.addr = 10'h000;
    l2.d = 18'h0;
    l2.byte_lane_write_mask_n = 2'b11;
    num_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // full writes around single-lane writes, a different lane on each beat
    req(1'b1, 10'h005, 36'h123456789, 36'hFEDCBA987, 4'h0, 4'h0);
    for (int i = 0; i < 4; i++)
      req(1'b1, 10'h005, 36'hFFFFFFFFF, 36'h0, ~(4'h1 << i),
        ~(4'h8 >> i));
    for (int i = 0; i < 4; i++)
      req(1'b1, 10'(i), {9{i[3:0]}}, ~{9{i[3:0]}}, 4'h0, 4'h0);
    idle(30);
    req(1'b0, 10'h005, 36'h0, 36'h0, 4'hF, 4'hF);
    // reads and writes back to back so both machines overlap
    for (int i = 0; i < 4; i++) begin
      req(1'b0, 10'(i), 36'h0, 36'h0, 4'hF, 4'hF);
      req(1'b1, 10'(i + 8), ~{9{i[3:0]}}, {9{i[3:0]}}, 4'h0, 4'h0);
    end
    idle(30);
    for (int i = 8; i < 12; i++)
      req(1'b0, 10'(i), 36'h0, 36'h0, 4'hF, 4'hF);
    idle(20);
    chk({36'h0, expq.size() == 0}, 37'h1);
    wr2(10'h007, 18'h2AAAA, 18'h15555, 2'b00, 2'b00);
    wr2(10'h007, 18'h3FFFF, 18'h00000, 2'b10, 2'b01);
    wr2(10'h007, 18'h00000, 18'h3FFFF, 2'b11, 2'b11);
    repeat (20) @(posedge clk_i);
    rd2(10'h007, 1'b1);
    rd2(10'h007, 1'b0);
    repeat (20) @(posedge clk_i);
    rd2(10'h007, 1'b1);
    test_done();
  end
endmodule
